// File: fsw_consts.svh
// Purpose: constants for the flash self-write sequencer and its CPU end
// Assumes: 25 MHz system clock, one byte-wide special register port
// Notes:   included by the package and by both ends
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH
// special register selects
`define FSW_SEL_DATL 3'h0
`define FSW_SEL_DATH 3'h1
`define FSW_SEL_ADRL 3'h2
`define FSW_SEL_ADRH 3'h3
`define FSW_SEL_CON1 3'h4
`define FSW_SEL_CON2 3'h5
// control register bits
`define FSW_BIT_RD   0
`define FSW_BIT_WR   1
`define FSW_BIT_WRITE_ENABLE_BIT 2
`define FSW_CON1_RST 8'h80
`define FSW_CON1_WE  8'h04
`define FSW_CON1_WR  8'h06
`define FSW_CON1_RD  8'h01
`define FSW_CON1_OFF 8'h00
// unlock key
`define FSW_KEY1 8'h55
`define FSW_KEY2 8'hAA
// geometry
`define FSW_BLK_LAST 2'h3
`define FSW_ERASED   14'h3FFF
`define FSW_WORDS    2048
`define FSW_ROW      16
// timing
`define FSW_CLK_MHZ   25
`define FSW_ERASE_US  4000
`define FSW_PWRT_US   64000
`define FSW_ERASE_CYC (`FSW_ERASE_US * `FSW_CLK_MHZ)
`define FSW_PWRT_CYC  (`FSW_PWRT_US * `FSW_CLK_MHZ)
// controller registers on the bus
`define FSW_OFS_CTRL 8'h00
`define FSW_OFS_ADDR 8'h04
`define FSW_OFS_DATA 8'h08
`define FSW_OFS_STAT 8'h0C
`define FSW_CTRL_WRITE 0
`define FSW_CTRL_READ  1
`define FSW_STAT_BUSY  31
`endif

// File: fsw_pkg.sv
// Purpose: types shared by both ends of the flash self-write link
// Assumes: constants come from fsw_consts.svh
// Notes:   state encodings follow Gray steps along the usual path, except the step back to idle
`include "fsw_consts.svh"
package fsw_pkg;
   typedef enum logic [1:0] {K_NONE = 2'h0, K_HALF = 2'h1, K_FULL = 2'h3} fsw_key_t;
   typedef enum logic [2:0] {
      D_IDLE = 3'h0, D_PREP1 = 3'h1, D_PREP2 = 3'h3, D_ERASE = 3'h2, D_PROG = 3'h6
   } fsw_dev_st_t;
   typedef enum logic [4:0] {
      C_IDLE = 5'h00, C_ALO = 5'h01, C_AHI = 5'h03, C_DLO = 5'h02, C_DHI = 5'h06,
      C_WEN = 5'h07, C_K55 = 5'h05, C_KAA = 5'h04, C_WRS = 5'h0C, C_NOP1 = 5'h0D,
      C_NOP2 = 5'h0F, C_HOLD = 5'h0E, C_WDIS = 5'h0A, C_RDS = 5'h0B, C_RGAP = 5'h09,
      C_RLO = 5'h08, C_RHI = 5'h18, C_RCAP = 5'h19
   } fsw_cpu_st_t;
   typedef struct packed {
      fsw_dev_st_t st;
      fsw_key_t    key;
      logic [7:0]  adrl;
      logic [2:0]  adrh;
      logic [7:0]  datl;
      logic [5:0]  dath;
      logic        write_enable_bit;
      logic        wr;
      logic        rd;
      logic [20:0] cnt;
      logic [20:0] pcnt;
      logic        pwrt_done;
      logic [1:0]  pidx;
      logic [7:0]  rdata;
      logic        stall;
      logic        test_mode;
      logic        busy;
      logic        ser_ref;
   } fsw_dev_s_t;
   typedef struct packed {
      logic       we;
      logic       re;
      logic [2:0] sel;
      logic [7:0] wd;
   } fsw_op_t;
   typedef struct packed {
      fsw_cpu_st_t st;
      logic        cmd_rd;
      logic [10:0] addr;
      logic [13:0] wdata;
      logic [13:0] rdata;
      logic        ph_we;
      logic [7:0]  ph_ofs;
      logic [31:0] hrdata;
      logic        hready;
      fsw_op_t     op;
   } fsw_cpu_s_t;
endpackage : fsw_pkg

// File: fsw_link_if.sv
// Purpose: special register link between CPU end and sequencer
// Assumes: both ends on the same clock
// Notes:   rdata answers one cycle after re
`timescale 1ns/10ps
interface fsw_link_if;
   logic [2:0] sel;
   logic       we;
   logic       re;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       stall;
   modport dev (input sel, we, re, wdata, output rdata, stall);
   modport cpu (output sel, we, re, wdata, input rdata, stall);
endinterface : fsw_link_if

// File: fsw_dev_end.sv
// Purpose: flash self-write sequencer with key unlock, buffer and row erase
// Assumes: link accesses are single-cycle strobes; 2K word flash array
// Notes:   serial programming port and test mode request sit on user side
`timescale 1ns/10ps
`include "fsw_consts.svh"
module fsw_dev_end #(
   parameter int unsigned PWRT_CYCLES  = `FSW_PWRT_CYC,
   parameter int unsigned ERASE_CYCLES = `FSW_ERASE_CYC
) (
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   fsw_link_if.dev          link,
   input  wire logic [3:0]  prot_seg_in,
   input  wire logic [3:0]  wrt_seg_in,
   input  wire logic        cp_in,
   input  wire logic        test_req_in,
   input  wire logic        ser_we_in,
   input  wire logic [10:0] ser_addr_in,
   input  wire logic [13:0] ser_data_in,
   output logic             test_mode_out,
   output logic             busy_out,
   output logic             ser_refused_out
);
   import fsw_pkg::*;

   fsw_dev_s_t  q;
   fsw_dev_s_t  d;
   logic [13:0] flash_mem [`FSW_WORDS];
   logic [13:0] blk_buf [4];
   logic [10:0] addr;
   logic [13:0] rd_word;
   logic        buf_we;
   logic        mem_erase;
   logic        mem_we;
   logic [10:0] mem_addr;
   logic [13:0] mem_data;

   // segment lock lookup by the two top address bits
   function automatic logic seg_hit(input logic [3:0] m, input logic [10:0] a);
      seg_hit = m[a[10:9]];
   endfunction : seg_hit

   assign addr    = {q.adrh, q.adrl};
   assign rd_word = flash_mem[addr];

   // next state of the sequencer
   always_comb begin
      d         = q;
      buf_we    = 1'b0;
      mem_erase = 1'b0;
      mem_we    = 1'b0;
      mem_addr  = 11'h000;
      mem_data  = 14'h0000;
      d.ser_ref = 1'b0;
      d.test_mode = test_req_in & ~cp_in;
      // power-up timer holds off writes
      if (!q.pwrt_done) begin
         d.pcnt = q.pcnt + 21'h000001;
         if (q.pcnt == 21'(PWRT_CYCLES - 1)) begin
            d.pwrt_done = 1'b1;
         end
      end
      // read completes in one cycle, allowed under code protect
      if (q.rd) begin
         d.datl = rd_word[7:0];
         d.dath = rd_word[13:8];
         d.rd   = 1'b0;
      end
      // non-final words finish at once
      if (q.st == D_IDLE && q.wr) begin
         d.wr = 1'b0;
      end
      // register reads
      if (link.re) begin
         case (link.sel)
            `FSW_SEL_DATL: d.rdata = q.datl;
            `FSW_SEL_DATH: d.rdata = {2'h0, q.dath};
            `FSW_SEL_ADRL: d.rdata = q.adrl;
            `FSW_SEL_ADRH: d.rdata = {5'h00, q.adrh};
            `FSW_SEL_CON1: d.rdata = `FSW_CON1_RST | {5'h00, q.write_enable_bit, q.wr, q.rd};
            `FSW_SEL_CON2: d.rdata = 8'h00;
            default:       d.rdata = 8'h00;
         endcase
      end
      // any access breaks a partial key unless it continues it
      if (link.re || link.we) begin
         d.key = K_NONE;
      end
      // register writes, ignored while the core is held
      if (link.we && !q.stall) begin
         case (link.sel)
            `FSW_SEL_DATL: d.datl = link.wdata;
            `FSW_SEL_DATH: d.dath = link.wdata[5:0];
            `FSW_SEL_ADRL: d.adrl = link.wdata;
            `FSW_SEL_ADRH: d.adrh = link.wdata[2:0];
            `FSW_SEL_CON2: begin
               if (q.key == K_NONE && link.wdata == `FSW_KEY1) begin
                  d.key = K_HALF;
               end else if (q.key == K_HALF && link.wdata == `FSW_KEY2) begin
                  d.key = K_FULL;
               end
            end
            `FSW_SEL_CON1: begin
               d.write_enable_bit = link.wdata[`FSW_BIT_WRITE_ENABLE_BIT];
               if (link.wdata[`FSW_BIT_RD]) begin
                  d.rd = 1'b1;
               end
               // start only after full key, with enable, timer done
               if (link.wdata[`FSW_BIT_WR] && q.key == K_FULL && q.write_enable_bit
                   && q.pwrt_done && q.st == D_IDLE && !q.wr) begin
                  buf_we = 1'b1;
                  d.wr   = 1'b1;
                  if (q.adrl[1:0] == `FSW_BLK_LAST) begin
                     d.st = D_PREP1;
                  end
               end
            end
            default: ;
         endcase
      end
      // erase and program sequence
      case (q.st)
         D_IDLE: ;
         D_PREP1: begin
            d.st    = D_PREP2;
            d.stall = 1'b1;
         end
         D_PREP2: begin
            d.st  = D_ERASE;
            d.cnt = 21'h000000;
         end
         D_ERASE: begin
            d.cnt = q.cnt + 21'h000001;
            if (q.cnt == 21'(ERASE_CYCLES - 1)) begin
               mem_erase = ~seg_hit(prot_seg_in, addr);
               mem_addr  = addr;
               d.st      = D_PROG;
               d.pidx    = 2'h0;
            end
         end
         D_PROG: begin
            mem_we   = ~seg_hit(prot_seg_in, addr);
            mem_addr = {addr[10:2], q.pidx};
            mem_data = blk_buf[q.pidx];
            d.pidx   = q.pidx + 2'h1;
            if (q.pidx == `FSW_BLK_LAST) begin
               d.st    = D_IDLE;
               d.stall = 1'b0;
               d.wr    = 1'b0;
            end
         end
         default: d.st = D_IDLE;
      endcase
      // serial programming, refused in write-protected areas or under protect
      if (ser_we_in) begin
         if (cp_in || seg_hit(wrt_seg_in, ser_addr_in) || q.st != D_IDLE) begin
            d.ser_ref = 1'b1;
         end else begin
            mem_we   = 1'b1;
            mem_addr = ser_addr_in;
            mem_data = ser_data_in;
         end
      end
      d.busy = (d.st != D_IDLE);
   end

   // state register
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         q       <= '0;
         q.st    <= D_IDLE;
         q.key   <= K_NONE;
         q.write_enable_bit  <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // buffer and flash array
   always_ff @(posedge clk_in) begin
      if (buf_we) begin
         blk_buf[q.adrl[1:0]] <= {q.dath, q.datl};
      end
      if (mem_erase) begin
         for (int i = 0; i < `FSW_ROW; i++) begin
            flash_mem[{mem_addr[10:4], 4'(i)}] <= `FSW_ERASED;
         end
      end else if (mem_we) begin
         flash_mem[mem_addr] <= mem_data;
      end
   end

   assign link.rdata      = q.rdata;
   assign link.stall      = q.stall;
   assign test_mode_out   = q.test_mode;
   assign busy_out        = q.busy;
   assign ser_refused_out = q.ser_ref;
endmodule : fsw_dev_end

// File: fsw_cpu_end.sv
// Purpose: CPU end that runs the unlock and load sequences on command
// Assumes: AHB-Lite slave, zero wait states, word accesses only
// Notes:   busy commands are dropped; status shows busy and read word
`timescale 1ns/10ps
`include "fsw_consts.svh"
module fsw_cpu_end (
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic             hreadyout_out,
   output logic [31:0]      hrdata_out,
   output logic             hresp_out,
   fsw_link_if.cpu          link
);
   import fsw_pkg::*;

   fsw_cpu_s_t q;
   fsw_cpu_s_t d;

   // link access issued while in a given state
   function automatic fsw_op_t op_of(input fsw_cpu_st_t s, input fsw_cpu_s_t v);
      op_of = '0;
      case (s)
         C_ALO:  op_of = '{1'b1, 1'b0, `FSW_SEL_ADRL, v.addr[7:0]};
         C_AHI:  op_of = '{1'b1, 1'b0, `FSW_SEL_ADRH, {5'h00, v.addr[10:8]}};
         C_DLO:  op_of = '{1'b1, 1'b0, `FSW_SEL_DATL, v.wdata[7:0]};
         C_DHI:  op_of = '{1'b1, 1'b0, `FSW_SEL_DATH, {2'h0, v.wdata[13:8]}};
         C_WEN:  op_of = '{1'b1, 1'b0, `FSW_SEL_CON1, `FSW_CON1_WE};
         C_K55:  op_of = '{1'b1, 1'b0, `FSW_SEL_CON2, `FSW_KEY1};
         C_KAA:  op_of = '{1'b1, 1'b0, `FSW_SEL_CON2, `FSW_KEY2};
         C_WRS:  op_of = '{1'b1, 1'b0, `FSW_SEL_CON1, `FSW_CON1_WR};
         C_WDIS: op_of = '{1'b1, 1'b0, `FSW_SEL_CON1, `FSW_CON1_OFF};
         C_RDS:  op_of = '{1'b1, 1'b0, `FSW_SEL_CON1, `FSW_CON1_RD};
         C_RLO:  op_of = '{1'b0, 1'b1, `FSW_SEL_DATL, 8'h00};
         C_RHI:  op_of = '{1'b0, 1'b1, `FSW_SEL_DATH, 8'h00};
         default: op_of = '0;
      endcase
   endfunction : op_of

   // bus slave and sequencer
   always_comb begin
      d = q;
      // data phase of a write
      if (q.ph_we) begin
         d.ph_we = 1'b0;
         case (q.ph_ofs)
            `FSW_OFS_CTRL: begin
               if (q.st == C_IDLE && (hwdata_in[`FSW_CTRL_WRITE] || hwdata_in[`FSW_CTRL_READ])) begin
                  d.st     = C_ALO;
                  d.cmd_rd = ~hwdata_in[`FSW_CTRL_WRITE];
               end
            end
            `FSW_OFS_ADDR: if (q.st == C_IDLE) d.addr = hwdata_in[10:0];
            `FSW_OFS_DATA: if (q.st == C_IDLE) d.wdata = hwdata_in[13:0];
            default: ;
         endcase
      end
      // address phase
      if (hsel_in && htrans_in[1] && hready_in) begin
         d.ph_we  = hwrite_in;
         d.ph_ofs = haddr_in[7:0];
         case (haddr_in[7:0])
            `FSW_OFS_ADDR: d.hrdata = {21'h000000, q.addr};
            `FSW_OFS_DATA: d.hrdata = {18'h00000, q.wdata};
            `FSW_OFS_STAT: d.hrdata = {q.st != C_IDLE, 17'h00000, q.rdata};
            default:       d.hrdata = 32'h00000000;
         endcase
      end
      // walk through the link sequence
      case (q.st)
         C_IDLE: ;
         C_ALO:  d.st = C_AHI;
         C_AHI:  d.st = q.cmd_rd ? C_RDS : C_DLO;
         C_DLO:  d.st = C_DHI;
         C_DHI:  d.st = C_WEN;
         C_WEN:  d.st = C_K55;
         C_K55:  d.st = C_KAA;
         C_KAA:  d.st = C_WRS;
         C_WRS:  d.st = C_NOP1;
         C_NOP1: d.st = C_NOP2;
         C_NOP2: d.st = C_HOLD;
         C_HOLD: if (!link.stall) d.st = C_WDIS;
         C_WDIS: d.st = C_IDLE;
         C_RDS:  d.st = C_RGAP;
         C_RGAP: d.st = C_RLO;
         C_RLO:  d.st = C_RHI;
         C_RHI: begin
            d.st         = C_RCAP;
            d.rdata[7:0] = link.rdata;
         end
         C_RCAP: begin
            d.st          = C_IDLE;
            d.rdata[13:8] = link.rdata[5:0];
         end
         default: d.st = C_IDLE;
      endcase
      d.op     = op_of(d.st, d);
      d.hready = 1'b1;
   end

   // state register
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         q    <= '0;
         q.st <= C_IDLE;
      end else begin
         q <= d;
      end
   end

   assign hreadyout_out = q.hready;
   assign hrdata_out    = q.hrdata;
   assign hresp_out     = 1'b0;
   assign link.we       = q.op.we;
   assign link.re       = q.op.re;
   assign link.sel      = q.op.sel;
   assign link.wdata    = q.op.wd;
endmodule : fsw_cpu_end

// File: fsw_link_sva.sv
// Purpose: link checks for the flash self-write pair
// Assumes: one clock, synchronous active-high reset
// Notes:   shadows of key, enable and address judge each stall
`timescale 1ns/10ps
`include "fsw_consts.svh"
module fsw_link_sva #(
   parameter int unsigned PWRT_CYCLES  = 20,
   parameter int unsigned ERASE_CYCLES = 10
) (
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   input  wire logic [2:0] sel,
   input  wire logic       we,
   input  wire logic       re,
   input  wire logic [7:0] wdata,
   input  wire logic [7:0] rdata,
   input  wire logic       stall
);
   logic        k1_q;
   logic        k2_q;
   logic        write_enable_bit_q;
   logic [1:0]  adrl_q;
   logic [3:0]  gap_q;
   logic [7:0]  run_q;
   logic [31:0] pwrt_q;
   logic        key1_w;
   logic        key2_w;
   logic        st_w;
   logic        go_w;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // decode of key bytes and of start writes
   assign key1_w = we && sel == `FSW_SEL_CON2 && wdata == `FSW_KEY1;
   assign key2_w = we && sel == `FSW_SEL_CON2 && wdata == `FSW_KEY2;
   assign st_w   = we && sel == `FSW_SEL_CON1 && wdata[`FSW_BIT_WR];
   assign go_w   = st_w && k2_q && write_enable_bit_q && adrl_q == `FSW_BLK_LAST
                   && pwrt_q >= PWRT_CYCLES;
   // shadows of the device state seen on the link
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         k1_q   <= 1'b0;
         k2_q   <= 1'b0;
         write_enable_bit_q <= 1'b0;
         adrl_q <= 2'h0;
         gap_q  <= 4'hF;
         run_q  <= 8'h00;
         pwrt_q <= 32'h0;
      end else begin
         k1_q <= key1_w;
         k2_q <= key2_w && k1_q;
         if (we && !stall && sel == `FSW_SEL_CON1) write_enable_bit_q <= wdata[`FSW_BIT_WRITE_ENABLE_BIT];
         if (we && !stall && sel == `FSW_SEL_ADRL) adrl_q <= wdata[1:0];
         gap_q  <= go_w ? 4'h0 : (gap_q == 4'hF ? gap_q : gap_q + 4'h1);
         run_q  <= stall ? run_q + 8'h01 : 8'h00;
         if (pwrt_q < PWRT_CYCLES) pwrt_q <= pwrt_q + 32'h1;
      end
   end
   AST_KEY_ORDER: assert property (key1_w |=> key2_w ##1 st_w)
      else $error("key bytes not followed by start write");
   AST_PREP_IDLE: assert property (st_w |=> (!we && !re) [*2])
      else $error("access inside the two prepare cycles");
   AST_STALL_CAUSE: assert property ($rose(stall) |-> gap_q < 4'h4)
      else $error("stall without keyed start on final word");
   AST_STALL_WRITE_ENABLE_BIT: assert property ($rose(stall) |-> write_enable_bit_q)
      else $error("stall while write enable clear");
   AST_NO_STALL: assert property (st_w && adrl_q != `FSW_BLK_LAST && !stall
      |=> !stall [*6])
      else $error("stall after a non-final word");
   AST_STALL_LEN: assert property ($fell(stall) |-> run_q == ERASE_CYCLES + 5)
      else $error("stall length wrong");
   AST_PWRT: assert property (pwrt_q < PWRT_CYCLES |-> !stall)
      else $error("stall during power-up time");
   AST_RESUME: assert property ($fell(stall) |-> ##[0:3]
      (we && sel == `FSW_SEL_CON1 && wdata == `FSW_CON1_OFF))
      else $error("cpu end did not resume after stall");
endmodule : fsw_link_sva

// File: flash_self_write_sequencer_tb_top.sv
// Purpose: self-checking bench for the flash self-write pair
// Assumes: 25 MHz clock, shortened power-up and erase counts
// Notes:   software side speaks AHB-Lite to the CPU end
`timescale 1ns/10ps
`include "fsw_consts.svh"
module flash_self_write_sequencer_tb_top;
   logic        clk_in, reset_in, hsel, hwrite, hready, cp, treq, tmode;
   logic        ser_we, busy, sref;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [3:0]  prot, wrt;
   logic [10:0] ser_addr;
   logic [13:0] ser_data, rd;
   int          fail_count, checks_done, cyc, busy_n, ref_n;
   fsw_link_if link();
   fsw_dev_end #(.PWRT_CYCLES(20), .ERASE_CYCLES(10)) fsw_dev_end_i (
      .clk_in(clk_in), .reset_in(reset_in), .link(link), .prot_seg_in(prot),
      .wrt_seg_in(wrt), .cp_in(cp), .test_req_in(treq), .ser_we_in(ser_we),
      .ser_addr_in(ser_addr), .ser_data_in(ser_data), .test_mode_out(tmode),
      .busy_out(busy), .ser_refused_out(sref));
   fsw_cpu_end fsw_cpu_end_i (
      .clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hready), .hreadyout_out(hready), .hrdata_out(hrdata),
      .hresp_out(), .link(link));
   fsw_link_sva #(.PWRT_CYCLES(20), .ERASE_CYCLES(10)) fsw_link_sva_i (
      .clk_in(clk_in), .reset_in(reset_in), .sel(link.sel), .we(link.we),
      .re(link.re), .wdata(link.wdata), .rdata(link.rdata), .stall(link.stall));
   // clock of 40 ns
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   // cycle, busy and refusal counters with hang limit
   always @(posedge clk_in) begin
      cyc++;
      if (busy === 1'b1) busy_n++;
      if (sref === 1'b1) ref_n++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one phase: sample ready before the edge, leave after it
   task automatic phase(output logic [31:0] r);
      logic ok;
      do begin
         @(negedge clk_in);
         ok = hready;
         r = hrdata;
         @(posedge clk_in);
      end while (ok !== 1'b1);
   endtask : phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk_in);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      phase(r);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      phase(r);
   endtask : bus
   task automatic idle_wait(output logic [31:0] s);
      s = 32'h80000000;
      while (s[`FSW_STAT_BUSY] !== 1'b0) bus(1'b0, `FSW_OFS_STAT, 32'h0, s);
   endtask : idle_wait
   task automatic word(input logic w, input logic [10:0] a, input logic [13:0] d);
      logic [31:0] s;
      bus(1'b1, `FSW_OFS_ADDR, {21'h0, a}, s);
      if (w) bus(1'b1, `FSW_OFS_DATA, {18'h0, d}, s);
      bus(1'b1, `FSW_OFS_CTRL, w ? 32'h1 : 32'h2, s);
      idle_wait(s);
      rd = s[13:0];
   endtask : word
   // four ascending words, busy only on the last
   task automatic blk(input logic [10:0] b, input logic [13:0] d);
      busy_n = 0;
      for (int i = 0; i < 4; i++) begin
         if (i == 3) chk(32'(busy_n), 32'h0);
         word(1'b1, b + 11'(i), d + 14'(i));
      end
   endtask : blk
   task automatic t_power;
      busy_n = 0;
      word(1'b1, 11'h003, 14'h1234);
      chk(32'(busy_n), 32'h0);
      $display("test power-up lock done");
   endtask : t_power
   task automatic t_block;
      cp <= 1'b1;
      blk(11'h010, 14'h0ABC);
      chk({31'h0, busy_n > 0}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         word(1'b0, 11'h010 + 11'(i), 14'h0);
         chk({18'h0, rd}, {18'h0, 14'h0ABC + 14'(i)});
      end
      word(1'b0, 11'h014, 14'h0);
      chk({18'h0, rd}, {18'h0, `FSW_ERASED});
      word(1'b0, 11'h01F, 14'h0);
      chk({18'h0, rd}, {18'h0, `FSW_ERASED});
      cp <= 1'b0;
      $display("test block write done");
   endtask : t_block
   task automatic t_prot;
      blk(11'h040, 14'h1111);
      prot <= 4'h1;
      blk(11'h040, 14'h2222);
      word(1'b0, 11'h040, 14'h0);
      chk({18'h0, rd}, {18'h0, 14'h1111});
      prot <= 4'h0;
      $display("test protected segment done");
   endtask : t_prot
   task automatic ser(input logic [10:0] a, input int exp);
      ref_n = 0;
      @(posedge clk_in);
      ser_we   <= 1'b1;
      ser_addr <= a;
      ser_data <= 14'h0155;
      @(posedge clk_in);
      ser_we <= 1'b0;
      repeat (4) @(posedge clk_in);
      chk(32'(ref_n), 32'(exp));
   endtask : ser
   // cpu may still change a write-protected quarter, the serial port may not
   task automatic t_serial;
      wrt <= 4'h2;
      blk(11'h200, 14'h0AAA);
      ser(11'h200, 1);
      word(1'b0, 11'h200, 14'h0);
      chk({18'h0, rd}, {18'h0, 14'h0AAA});
      ser(11'h400, 0);
      word(1'b0, 11'h400, 14'h0);
      chk({18'h0, rd}, {18'h0, 14'h0155});
      wrt <= 4'h0;
      $display("test serial protect done");
   endtask : t_serial
   task automatic t_test;
      treq <= 1'b1;
      cp   <= 1'b1;
      repeat (3) @(posedge clk_in);
      chk({31'h0, tmode}, 32'h0);
      cp <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk({31'h0, tmode}, 32'h1);
      treq <= 1'b0;
      $display("test mode gate done");
   endtask : t_test
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   // reset, then the scenarios in turn
   initial begin
      {fail_count, checks_done, cyc, busy_n, ref_n} = '0;
      {hsel, hwrite, cp, treq, ser_we} = '0;
      {haddr, hwdata, htrans, prot, wrt, ser_addr, ser_data} = '0;
      reset_in = 1'b1;
      repeat (12) @(posedge clk_in);
      reset_in <= 1'b0;
      t_power();
      t_block();
      t_prot();
      t_serial();
      t_test();
      finish_test();
   end
endmodule : flash_self_write_sequencer_tb_top
